// ### page_ext_defs.svh
// offsets, field positions, reset values and boundary pages of the
// paged address extender; assumes a 12-bit apb byte address.
`ifndef PAGE_EXT_DEFS_SVH
`define PAGE_EXT_DEFS_SVH

// apb byte offsets, one aligned 32-bit word each
`define OFS_READ_PAGE   12'h000
`define OFS_WRITE_PAGE  12'h004
`define OFS_STATUS      12'h008
`define OFS_MASK        12'h00c

// page register widths
`define READ_PAGE_W     10
`define WRITE_PAGE_W    9

// page register reset values (page zero would trap at once)
`define READ_PAGE_RST   10'h001
`define WRITE_PAGE_RST  9'h001

// status and mask bit positions
`define EV_ADVANCE      0
`define EV_TO_BASE      1
`define EV_WRAP         2
`define EV_TRAP         3
`define EV_W            4
`define STATUS_RST      4'h0
`define MASK_RST        4'h0

// boundary pages, compared on a 10-bit page value
`define PG_EDS_LAST     10'h1ff
`define PG_LSW_LAST     10'h2ff
`define PG_MSB_FIRST    10'h300
`define PG_MSB_LAST     10'h3ff
`define PG_PSV_LOW      10'h001
`define PG_LSW_FIRST    10'h200
`define PG_ZERO         10'h000

`endif

// ### page_ext_pkg.sv
// types shared by the paged address extender and its bench;
// assumes the request comes from the cpu address generator.
`default_nettype none

package page_ext_pkg;

    // addressing mode of the effective address calculation
    typedef enum logic [2:0] {
        MODE_PLAIN   = 3'b000,   // no modification
        MODE_PREPOST = 3'b001,   // pre or post modified indirect
        MODE_OFFSET  = 3'b010,   // register offset indirect
        MODE_MODULO  = 3'b011,   // modulo addressing
        MODE_BITREV  = 3'b100    // bit-reversed addressing
    } mode_type;

    // which space the final address lands in
    typedef enum logic [1:0] {
        SPACE_BASE = 2'b00,
        SPACE_EDS  = 2'b01,
        SPACE_PSV  = 2'b10
    } space_type;

    // one access from the address generator
    typedef struct packed {
        logic        valid;      // access this cycle
        logic        write;      // 1 write, 0 read
        logic        psv_write;  // write aimed at program space
        logic        step_inc;   // 1 pointer stepped up, 0 down
        mode_type    mode;       // addressing mode
        logic [15:0] orig_ea;    // pointer before modification
        logic [15:0] calc_ea;    // pointer after modification
    } agu_req_type;

    // extended address handed back one cycle later
    typedef struct packed {
        logic        valid;      // result valid
        logic [23:0] addr;       // 24-bit address
        space_type   space;      // target space
        logic        trap;       // address error trap
    } agu_rsp_type;

endpackage

`default_nettype wire

// ### page_step.sv
// boundary-aware page stepper, purely combinational;
// assumes the caller has already decided overflow, underflow or wrap.
`default_nettype none
`include "page_ext_defs.svh"

module page_step #(
    parameter int PW = 10                    // page width as compared
) (
    input  wire logic [PW-1:0] cur_page,
    input  wire logic          is_write,
    input  wire logic          ovf,
    input  wire logic          unf,
    input  wire logic          wrap,
    output logic      [PW-1:0] new_page,
    output logic               keep_b15,
    output logic               to_base
);

    // read overflow at the last eds or last msb page stops
    wire rd_ovf_stop = !is_write && ovf &&
        (cur_page == `PG_EDS_LAST || cur_page == `PG_MSB_LAST);
    // write overflow at the last eds page stops
    wire wr_ovf_stop = is_write && ovf &&
        (cur_page == `PG_EDS_LAST);
    // read underflow at the low psv page or first lsw page stops
    wire rd_unf_stop = !is_write && unf &&
        (cur_page == `PG_PSV_LOW || cur_page == `PG_LSW_FIRST);

    // wrap modes never leave the page, so no boundary stop
    assign to_base  = !wrap && (rd_ovf_stop || wr_ovf_stop ||
                                rd_unf_stop);
    // bit 15 comes back set on overflow or underflow unless the access fell to base
    assign keep_b15 = (ovf || unf) && !to_base;

    // 0x2ff to 0x300 and back are the plain step on 10 bits
    assign new_page = (wrap || to_base) ? cur_page :
                      ovf ? cur_page + PW'(1) :
                      unf ? cur_page - PW'(1) :
                      cur_page;

endmodule

`default_nettype wire

// ### page_ext.sv
// paged data space address extender with apb register access;
// assumes the address generator presents one access per cycle and
// that apb inputs are synchronous to pclk.
`default_nettype none
`include "page_ext_defs.svh"

module page_ext #(
    parameter int ADDR_W = 12                 // apb address width
) (
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [ADDR_W-1:0]         paddr,
    input  wire logic [31:0]               pwdata,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    input  wire page_ext_pkg::agu_req_type agu_req,
    output page_ext_pkg::agu_rsp_type      agu_rsp,
    output logic                           irq
);

    // register state
    logic [`READ_PAGE_W-1:0]  rd_page_ff;    // read page register
    logic [`WRITE_PAGE_W-1:0] wr_page_ff;    // write page register
    logic [`EV_W-1:0]         status_ff;     // sticky events
    logic [`EV_W-1:0]         mask_ff;       // interrupt enables
    logic [31:0]              prdata_ff;     // read data
    logic                     pready_ff;     // access ready
    logic                     pslverr_ff;    // unmapped answer
    logic                     irq_ff;        // interrupt level
    page_ext_pkg::agu_rsp_type rsp_ff;       // registered result

    // apb phase decode
    wire setup   = psel && !penable;
    wire apb_end = psel && penable && pready_ff;
    wire apb_wr  = apb_end && pwrite;
    wire [ADDR_W-1:0] word_addr = {paddr[ADDR_W-1:2], 2'b00};

    // register selects
    wire sel_rdpg  = word_addr == ADDR_W'(`OFS_READ_PAGE);
    wire sel_wrpg  = word_addr == ADDR_W'(`OFS_WRITE_PAGE);
    wire sel_stat  = word_addr == ADDR_W'(`OFS_STATUS);
    wire sel_mask  = word_addr == ADDR_W'(`OFS_MASK);
    wire mapped    = sel_rdpg || sel_wrpg || sel_stat || sel_mask;

    // read mux, narrow registers sit in the low bits
    wire [31:0] rd_mux =
        sel_rdpg ? {22'h00_0000, rd_page_ff} :
        sel_wrpg ? {23'h00_0000, wr_page_ff} :
        sel_stat ? {28'h000_0000, status_ff} :
        sel_mask ? {28'h000_0000, mask_ff} :
        32'h0000_0000;

    // apb answer: ready in the first cycle of the access phase
    wire        nxt_pready  = setup && !pready_ff;
    wire [31:0] nxt_prdata  = setup ? rd_mux : prdata_ff;
    wire        nxt_pslverr = setup ? !mapped : pslverr_ff;

    // access decode
    wire in_window = agu_req.orig_ea[15];
    wire crossed   = in_window && !agu_req.calc_ea[15];
    wire mode_pp   = agu_req.mode == page_ext_pkg::MODE_PREPOST;
    wire mode_wrap = agu_req.mode == page_ext_pkg::MODE_OFFSET ||
                     agu_req.mode == page_ext_pkg::MODE_MODULO ||
                     agu_req.mode == page_ext_pkg::MODE_BITREV;
    wire det_ovf   = mode_pp && crossed && agu_req.step_inc;
    wire det_unf   = mode_pp && crossed && !agu_req.step_inc;
    wire det_wrap  = mode_wrap && crossed;

    // the page of this access's own direction only
    wire [`READ_PAGE_W-1:0] sel_page = agu_req.write ?
        {1'b0, wr_page_ff} : rd_page_ff;

    // boundary stepper outputs
    logic [`READ_PAGE_W-1:0] step_page;
    logic                    step_b15;
    logic                    step_base;

    page_step #(
        .PW       (`READ_PAGE_W)
    ) u_step (
        .cur_page (sel_page),
        .is_write (agu_req.write),
        .ovf      (det_ovf),
        .unf      (det_unf),
        .wrap     (det_wrap),
        .new_page (step_page),
        .keep_b15 (step_b15),
        .to_base  (step_base)
    );

    // corrected effective address
    wire fix_b15 = crossed ? (step_b15 || det_wrap) :
                   agu_req.calc_ea[15];
    wire [15:0] fin_ea = {fix_b15, agu_req.calc_ea[14:0]};
    wire [`READ_PAGE_W-1:0] use_page = (det_ovf || det_unf) ?
                                       step_page : sel_page;
    wire page_chg = agu_req.valid && (use_page != sel_page);

    // final address formation
    wire is_psv = !agu_req.write && use_page[9];
    wire [23:0] ext_addr = {use_page[8:0], fin_ea[14:0]};
    wire [23:0] base_addr = {8'h00, fin_ea};
    wire [23:0] fin_addr = fix_b15 ? ext_addr : base_addr;
    wire page_zero = use_page == `PG_ZERO;
    wire trap_cond = (fix_b15 && page_zero) ||
                     (agu_req.write && agu_req.psv_write);
    page_ext_pkg::space_type fin_space;
    assign fin_space = !fix_b15 ? page_ext_pkg::SPACE_BASE :
                       is_psv ? page_ext_pkg::SPACE_PSV :
                       page_ext_pkg::SPACE_EDS;

    page_ext_pkg::agu_rsp_type nxt_rsp;
    assign nxt_rsp = '{valid: agu_req.valid,
                       addr:  fin_addr,
                       space: fin_space,
                       trap:  agu_req.valid && trap_cond};

    // page register next values; hardware stepping beats software
    wire hw_rd = page_chg && !agu_req.write;
    wire hw_wr = page_chg && agu_req.write;
    wire [`READ_PAGE_W-1:0] nxt_rd_page =
        hw_rd ? use_page :
        (apb_wr && sel_rdpg) ? pwdata[`READ_PAGE_W-1:0] : rd_page_ff;
    wire [`WRITE_PAGE_W-1:0] nxt_wr_page =
        hw_wr ? use_page[`WRITE_PAGE_W-1:0] :
        (apb_wr && sel_wrpg) ? pwdata[`WRITE_PAGE_W-1:0] : wr_page_ff;

    // events, set wins over a same-cycle write-one-to-clear
    // so a clear that lands with a new event never loses the event
    logic [`EV_W-1:0] events;
    assign events[`EV_ADVANCE] = page_chg;
    assign events[`EV_TO_BASE] = agu_req.valid && crossed && step_base;
    assign events[`EV_WRAP]    = agu_req.valid && det_wrap;
    assign events[`EV_TRAP]    = agu_req.valid && trap_cond;
    wire [`EV_W-1:0] w1c = (apb_wr && sel_stat) ?
                           pwdata[`EV_W-1:0] : `STATUS_RST;
    wire [`EV_W-1:0] nxt_status = (status_ff & ~w1c) | events;
    wire [`EV_W-1:0] nxt_mask = (apb_wr && sel_mask) ?
                                pwdata[`EV_W-1:0] : mask_ff;
    wire nxt_irq = |(nxt_status & nxt_mask);

    // page registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_page_ff <= `READ_PAGE_RST;
            wr_page_ff <= `WRITE_PAGE_RST;
        end else begin
            rd_page_ff <= nxt_rd_page;
            wr_page_ff <= nxt_wr_page;
        end
    end

    // status, mask and interrupt level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_ff <= `STATUS_RST;
            mask_ff   <= `MASK_RST;
            irq_ff    <= 1'b0;
        end else begin
            status_ff <= nxt_status;
            mask_ff   <= nxt_mask;
            irq_ff    <= nxt_irq;
        end
    end

    // apb answer registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff  <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff  <= nxt_pready;
            prdata_ff  <= nxt_prdata;
            pslverr_ff <= nxt_pslverr;
        end
    end

    // result register, one cycle behind the request
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rsp_ff <= '0;
        end else begin
            rsp_ff <= nxt_rsp;
        end
    end

    assign prdata  = prdata_ff;
    assign pready  = pready_ff;
    assign pslverr = pslverr_ff;
    assign agu_rsp = rsp_ff;
    assign irq     = irq_ff;

    // checks on the page logic
    // each takes the request at one edge and the registered answer
    // at the next, so outputs are looked at once they have settled,
    // never in the step that launched them
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    wire rq_rd = agu_req.valid && !agu_req.write;
    wire rq_wr = agu_req.valid && agu_req.write;

    a_base_pass: assert property (
        agu_req.valid && !agu_req.orig_ea[15] && !agu_req.calc_ea[15]
        |=> agu_rsp.addr == {8'h00, $past(agu_req.calc_ea)} &&
            agu_rsp.space == page_ext_pkg::SPACE_BASE)
        else $error("base address not passed unchanged");

    a_rd_concat: assert property (
        rq_rd && agu_req.mode == page_ext_pkg::MODE_PLAIN &&
        agu_req.calc_ea[15] && !rd_page_ff[9]
        |=> agu_rsp.addr == {$past(rd_page_ff[8:0]),
                             $past(agu_req.calc_ea[14:0])})
        else $error("read extended address wrong");

    a_wr_concat: assert property (
        rq_wr && agu_req.mode == page_ext_pkg::MODE_PLAIN &&
        agu_req.calc_ea[15]
        |=> agu_rsp.addr == {$past(wr_page_ff),
                             $past(agu_req.calc_ea[14:0])})
        else $error("write extended address wrong");

    a_ovf_step: assert property (
        rq_rd && mode_pp && crossed && agu_req.step_inc &&
        rd_page_ff != `PG_EDS_LAST && rd_page_ff != `PG_MSB_LAST
        |=> rd_page_ff == $past(rd_page_ff) + 10'h001 &&
            agu_rsp.space != page_ext_pkg::SPACE_BASE)
        else $error("overflow did not advance read page");

    a_unf_step: assert property (
        rq_wr && mode_pp && crossed && !agu_req.step_inc
        |=> wr_page_ff == $past(wr_page_ff) - 9'h001)
        else $error("underflow did not step write page back");

    a_wrap_hold: assert property (
        agu_req.valid && det_wrap && !apb_wr
        |=> $stable(rd_page_ff) && $stable(wr_page_ff) &&
            agu_rsp.space != page_ext_pkg::SPACE_BASE)
        else $error("wrap mode changed a page");

    a_edge_stop: assert property (
        rq_wr && det_ovf && wr_page_ff == 9'h1ff && !apb_wr
        |=> wr_page_ff == 9'h1ff &&
            agu_rsp.space == page_ext_pkg::SPACE_BASE)
        else $error("write overflow at last page not to base");

    a_psv_cross: assert property (
        rq_rd && det_ovf && rd_page_ff == `PG_LSW_LAST
        |=> rd_page_ff == `PG_MSB_FIRST ##0
            agu_rsp.space == page_ext_pkg::SPACE_PSV)
        else $error("lsw to msb overflow wrong");

    a_unf_base: assert property (
        rq_rd && det_unf && rd_page_ff == `PG_LSW_FIRST && !apb_wr
        |=> rd_page_ff == `PG_LSW_FIRST &&
            agu_rsp.addr[23:16] == 8'h00 && status_ff[`EV_TO_BASE])
        else $error("underflow at first lsw page not to base");

    a_psv_back: assert property (
        rq_rd && det_unf && rd_page_ff == `PG_MSB_FIRST
        |=> rd_page_ff == `PG_LSW_LAST)
        else $error("msb to lsw underflow wrong");

    a_zero_trap: assert property (
        rq_rd && agu_req.mode == page_ext_pkg::MODE_PLAIN &&
        agu_req.calc_ea[15] && rd_page_ff == `PG_ZERO
        |=> agu_rsp.trap && status_ff[`EV_TRAP] &&
            irq == |(status_ff & mask_ff))
        else $error("page zero access did not trap");

    a_psv_wr_trap: assert property (
        rq_wr && agu_req.psv_write
        |=> agu_rsp.trap && status_ff[`EV_TRAP])
        else $error("program space write did not trap");

endmodule

`default_nettype wire

// ### agu_model.sv
// cpu address generator model: issues one access per call;
// assumes calls are made right after a rising edge of pclk.
`default_nettype none

module agu_model (
    input  wire logic                 pclk,
    output page_ext_pkg::agu_req_type agu_req
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle, valid low, from time zero
    initial agu_req = '0;

    // hold one access for one edge; gap 0 lets the next call follow at
    // once, a larger gap models a slow generator with idle cycles
    task automatic issue(input page_ext_pkg::agu_req_type r,
                         input int gap);
        agu_req <= r;
        @(posedge pclk);
        if (gap > 0) begin
            agu_req.valid <= 1'b0;
            repeat (gap) @(posedge pclk);
        end
    endtask
endmodule

`default_nettype wire

// ### page_ext_bench.sv
// self-checking bench for the paged address extender;
// assumes the agu model and the design headers are compiled first.
`default_nettype none
`include "page_ext_defs.svh"

module page_ext_bench;
    timeunit 1ns;
    timeprecision 1ps;

    logic                      pclk;    // 100 MHz
    logic                      presetn; // async, active low
    logic                      psel;
    logic                      penable;
    logic                      pwrite;
    logic [11:0]               paddr;
    logic [31:0]               pwdata;
    logic [31:0]               prdata;
    logic                      pready;
    logic                      pslverr;
    page_ext_pkg::agu_req_type agu_req;
    page_ext_pkg::agu_rsp_type agu_rsp;
    logic                      irq;
    int                        error_cnt;
    int                        check_count;
    int                        cyc;
    logic [9:0]                rp;      // expected read page
    logic [8:0]                wp;      // expected write page
    logic [3:0]                st;      // expected sticky status
    logic [32:0]               rd_q[$]; // {slverr, data} per read
    page_ext_pkg::agu_rsp_type rsp_q[$];

    page_ext #(.ADDR_W(12)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .agu_req(agu_req),
        .agu_rsp(agu_rsp), .irq(irq));
    agu_model agu (.pclk(pclk), .agu_req(agu_req));

    // clock generator
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic bad(input string s);
        error_cnt++;
        $display("MISMATCH %0t %s", $time, s);
    endtask

    task automatic final_report();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // compare tasks, one per kind of result
    task automatic cmp_rd(input logic [32:0] got);
        check_count++;
        if (rd_q.size() == 0) bad("unexpected read");
        else if (got !== rd_q.pop_front()) bad("read data");
    endtask
    task automatic cmp_rsp(input page_ext_pkg::agu_rsp_type got);
        check_count++;
        if (rsp_q.size() == 0) bad("unexpected rsp");
        else if (got !== rsp_q.pop_front()) bad("agu response");
    endtask
    task automatic cmp_bit(input logic got, input logic exp);
        check_count++;
        if (got !== exp) bad("irq level");
    endtask

    // watcher: takes the oldest note whenever a result appears
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite)
            cmp_rd({pslverr, prdata});
        if (agu_rsp.valid === 1'b1)
            cmp_rsp(agu_rsp);
    end

    // hang guard, well above the expected run length
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            bad("timeout");
            final_report();
        end
    end

    // one apb transfer; holds everything until pready is seen high
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        // a transfer released in this time step gets one idle edge
        if (penable === 1'b1) @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // no assumed latency: only the hang guard ends this wait
        do @(posedge pclk);
        while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [32:0] e);
        rd_q.push_back(e);
        apb(1'b0, a, 32'h0000_0000);
    endtask

    // note the expected result, track pages, then issue the access
    task automatic go(input logic w, pw, inc,
                      input page_ext_pkg::mode_type m,
                      input logic [15:0] o, c, input int gap);
        page_ext_pkg::agu_rsp_type x;
        logic [9:0] pg;
        logic cr, b15, adv, base, wr;
        cr = o[15] & ~c[15];
        pg = w ? {1'b0, wp} : rp;
        b15 = c[15];
        adv = 1'b0;
        base = 1'b0;
        wr = 1'b0;
        if (cr && m == page_ext_pkg::MODE_PREPOST) begin
            if ((inc && (pg == `PG_EDS_LAST ||
                         (!w && pg == `PG_MSB_LAST))) ||
                (!inc && !w && (pg == `PG_PSV_LOW ||
                                pg == `PG_LSW_FIRST))) begin
                base = 1'b1;
            end else begin
                pg = inc ? pg + 10'h001 : pg - 10'h001;
                b15 = 1'b1;
                adv = 1'b1;
            end
        end else if (cr && m != page_ext_pkg::MODE_PLAIN) begin
            b15 = 1'b1;
            wr = 1'b1;
        end
        if (w) wp = pg[8:0];
        else rp = pg;
        x.valid = 1'b1;
        x.trap = (b15 && pg[8:0] == 9'h000 && (w || !pg[9])) ||
                 (w && pw);
        x.space = !b15 ? page_ext_pkg::SPACE_BASE :
                  (!w && pg[9]) ? page_ext_pkg::SPACE_PSV :
                  page_ext_pkg::SPACE_EDS;
        x.addr = b15 ? {pg[8:0], c[14:0]} : {8'h00, c};
        st = st | {x.trap, wr, base, adv};
        rsp_q.push_back(x);
        agu.issue('{1'b1, w, pw, inc, m, o, c}, gap);
    endtask

    logic [9:0] picks[8] = '{10'h001, 10'h005, 10'h1ff, 10'h200,
                             10'h2ff, 10'h300, 10'h3ff, 10'h0a5};

    initial begin
        logic [15:0] o;
        logic [9:0] p;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        error_cnt = 0;
        check_count = 0;
        cyc = 0;
        rp = `READ_PAGE_RST;
        wp = `WRITE_PAGE_RST;
        st = `STATUS_RST;
        void'($urandom(14725));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // reset values, unmapped word, register widths
        rd(`OFS_READ_PAGE, {1'b0, 32'h0000_0001});
        rd(`OFS_WRITE_PAGE, {1'b0, 32'h0000_0001});
        rd(`OFS_STATUS, 33'h0_0000_0000);
        rd(`OFS_MASK, 33'h0_0000_0000);
        rd(12'h010, 33'h1_0000_0000);
        apb(1'b1, `OFS_READ_PAGE, 32'hffff_ffff);
        apb(1'b1, `OFS_WRITE_PAGE, 32'hffff_ffff);
        rd(`OFS_READ_PAGE, {1'b0, 32'h0000_03ff});
        rd(`OFS_WRITE_PAGE, {1'b0, 32'h0000_01ff});
        $display("test registers done");
        // boundary pages, all modes, read then write back to back
        repeat (150) begin
            p = picks[$urandom % 8];
            rp = p;
            wp = picks[$urandom % 8][8:0];
            apb(1'b1, `OFS_READ_PAGE, {22'h0, rp});
            apb(1'b1, `OFS_WRITE_PAGE, {23'h0, wp});
            o = 16'($urandom);
            if ($urandom % 4 != 0) o[15] = 1'b1;
            go(1'b0, 1'b0, 1'($urandom), page_ext_pkg::mode_type'(
               $urandom % 5), o, 16'($urandom), 0);
            go(1'b1, ($urandom % 4 == 0), 1'($urandom),
               page_ext_pkg::mode_type'($urandom % 5), o,
               16'($urandom), 1 + $urandom % 2);
            rd(`OFS_READ_PAGE, {23'h0, rp});
            rd(`OFS_WRITE_PAGE, {24'h0, wp});
        end
        // directed: page zero in the window, write overflow at last page
        rp = 10'h000;
        apb(1'b1, `OFS_READ_PAGE, 32'h0000_0000);
        go(1'b0, 1'b0, 1'b0, page_ext_pkg::MODE_PLAIN, 16'h8000,
           16'h8002, 1);
        wp = 9'h1ff;
        apb(1'b1, `OFS_WRITE_PAGE, 32'h0000_01ff);
        go(1'b1, 1'b0, 1'b1, page_ext_pkg::MODE_PREPOST, 16'hfffe,
           16'h0000, 1);
        rd(`OFS_WRITE_PAGE, {24'h0, wp});
        $display("test paging done");
        // sticky status, mask and level interrupt
        rd(`OFS_STATUS, {29'h0, st});
        cmp_bit(irq, 1'b0);
        apb(1'b1, `OFS_MASK, 32'h0000_000f);
        repeat (2) @(posedge pclk);
        cmp_bit(irq, |st);
        apb(1'b1, `OFS_STATUS, {28'h0, st});
        repeat (2) @(posedge pclk);
        cmp_bit(irq, 1'b0);
        rd(`OFS_STATUS, 33'h0_0000_0000);
        rd(`OFS_MASK, {1'b0, 32'h0000_000f});
        $display("test interrupt done");
        repeat (3) @(posedge pclk);
        if (rd_q.size() != 0 || rsp_q.size() != 0) bad("results missing");
        final_report();
    end
endmodule

`default_nettype wire
